/* File: rtl/adc_filter_sync_control.sv */
// Filter-side control: modulator clocking, sync, reset, power-down and AHB registers.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module adc_filter_sync_control
    import adc_sync_pkg::*;
#(
    parameter int MCLK_HALF = MCLK_HALF_CYC
)
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    input  wire logic        reset_request,
    input  wire logic        power_down_request,
    input  wire logic        trigger_request,
    input  wire logic        high_rate_select,
    input  wire logic        decimation_select_2,
    input  wire logic        decimation_select_1,
    input  wire logic        decimation_select_0,
    input  wire logic        channel_select,
    input  wire logic        apply_offset_correction,
    input  wire logic        offset_cal_request,
    input  wire logic        modulator_bitstream,
    input  wire logic        modulator_unstable_flag,
    output logic             modulator_master_clock,
    output logic             modulator_phase_strobe,
    output logic             word_ready_flag,
    output logic [23:0]      word_data,
    output logic             error_flag,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata
);

    localparam logic [7:0] HALF_LAST = 8'(MCLK_HALF - 1);

    // Bits of the word period, limited to the largest documented ratio.
    function automatic logic [3:0] period_log2(input logic [2:0] dec);
        logic [2:0] d;
        d = (dec > DEC_MAX_SEL) ? DEC_MAX_SEL : dec;
        return 4'(DEC_BASE_LOG2 + {1'b0, d});
    endfunction : period_log2

    // Ones density over 2^k samples mapped onto the scaled output code.
    function automatic logic [23:0] scale_word(input logic [12:0] ones, input logic [3:0] k);
        logic signed [14:0] diff;
        logic signed [31:0] v;
        diff = $signed({1'b0, ones, 1'b0}) - $signed(15'(15'h1 << k));
        v = $signed({{17{diff[14]}}, diff}) * $signed(SCALE_MULT);
        v = v <<< (SCALE_LOG2 - {1'b0, k});
        // full density lands one above the top code, so clamp it.
        if (v > $signed({8'h00, CODE_POS_FULL}))
        begin
            v = $signed({8'h00, CODE_POS_FULL});
        end
        return v[23:0];
    endfunction : scale_word

    ctl_state_t st_reg;
    ctl_state_t st_next;

    cfg_t        pin_cfg;
    cfg_t        eff_cfg;
    logic        trig_ev;
    logic        mclk_rise;
    logic        mod_tick;
    logic [2:0]  div_last;
    logic [3:0]  k;
    logic [12:0] period_last;
    logic        period_end;
    logic        bus_take;

    always_comb
    begin
        pin_cfg.sw_mode   = 1'b0;
        pin_cfg.cal_req   = offset_cal_request;
        pin_cfg.use_off   = apply_offset_correction;
        pin_cfg.chan      = channel_select;
        pin_cfg.high_rate = high_rate_select;
        pin_cfg.dec       = {decimation_select_2, decimation_select_1, decimation_select_0};
        eff_cfg           = st_reg.cfg.sw_mode ? st_reg.cfg : pin_cfg;
    end

    assign trig_ev     = trigger_request && !st_reg.trig_prev;
    assign div_last    = eff_cfg.high_rate ? DIV_LAST_FAST : DIV_LAST_SLOW;
    assign mclk_rise   = (st_reg.div_cnt == HALF_LAST) && !st_reg.mclk;
    assign mod_tick    = mclk_rise && (st_reg.mod_cnt == div_last);
    assign k           = period_log2(eff_cfg.dec);
    assign period_last = 13'((13'h1 << k) - 13'h1);
    assign period_end  = mod_tick && (st_reg.sample_cnt == period_last);
    assign bus_take    = hsel && htrans[1] && hready;

    always_comb
    begin
        st_next           = st_reg;
        st_next.rst_seen  = reset_request;
        st_next.trig_prev = trigger_request;
        st_next.flag_prev = modulator_unstable_flag;

        // Master clock divider; the strobe lasts the low half of one master clock period.
        if (st_reg.div_cnt == HALF_LAST)
        begin
            st_next.div_cnt = 8'h00;
            st_next.mclk    = !st_reg.mclk;
        end
        else
        begin
            st_next.div_cnt = 8'(st_reg.div_cnt + 8'h01);
        end
        if (mclk_rise)
        begin
            st_next.mod_cnt = (st_reg.mod_cnt == div_last) ? 3'h0 : 3'(st_reg.mod_cnt + 3'h1);
            st_next.strobe  = 1'b0;
        end

        case (st_reg.mode)
            S_RESET:
            begin
                // leave power-on reset on first edge
                st_next.mode = S_IDLE;
            end
            S_IDLE:
            begin
                // wait for a trigger, enter power-down at once
                if (power_down_request)
                begin
                    st_next.mode = S_PDOWN;
                end
                else if (trig_ev)
                begin
                    // start and raise ready at once
                    st_next.mode = S_RUN;
                    if (!st_reg.ready)
                    begin
                        st_next.ready = 1'b1;
                    end
                end
            end
            S_RUN:
            begin
                if (power_down_request)
                begin
                    st_next.mode = S_PDOWN;
                end
                else if (period_end)
                begin
                    st_next.word       = scale_word(13'(st_reg.ones_cnt + {12'h000,
                                                    modulator_bitstream}), k);
                    st_next.ready      = 1'b1;
                    st_next.sample_cnt = 13'h0000;
                    st_next.ones_cnt   = 13'h0000;
                end
                else if (mod_tick)
                begin
                    st_next.sample_cnt = 13'(st_reg.sample_cnt + 13'h0001);
                    st_next.ones_cnt   = 13'(st_reg.ones_cnt + {12'h000, modulator_bitstream});
                end
                if (modulator_unstable_flag && !st_reg.flag_prev)
                begin
                    st_next.error = 1'b1;
                end
            end
            S_PDOWN:
            begin
                // clock and strobe held low, data left alone
                st_next.div_cnt = 8'h00;
                st_next.mclk    = 1'b0;
                st_next.mod_cnt = 3'h0;
                st_next.strobe  = 1'b0;
                // leave on first edge after low
                if (!power_down_request)
                begin
                    st_next.mode = S_IDLE;
                end
            end
            default:
            begin
                st_next.mode = S_RESET;
            end
        endcase

        // in-step trigger is ignored, any other in idle or run realigns unless power-down is requested
        if (trig_ev && !power_down_request &&
            ((st_reg.mode == S_IDLE) || ((st_reg.mode == S_RUN) && (st_reg.sample_cnt != 13'h0000))))
        begin
            // phase strobe restarts the modulator divider
            st_next.strobe     = 1'b1;
            st_next.div_cnt    = 8'h00;
            st_next.mclk       = 1'b0;
            st_next.mod_cnt    = 3'h0;
            st_next.sample_cnt = 13'h0000;
            st_next.ones_cnt   = 13'h0000;
        end

        // register port stays live in every mode
        st_next.wr_pend = bus_take && hwrite;
        if (bus_take)
        begin
            st_next.wr_addr = haddr[7:0];
        end
        if (st_reg.wr_pend && (st_reg.wr_addr == CONFIG_OFS))
        begin
            st_next.cfg = cfg_t'(hwdata[7:0] & CONFIG_WRITE_MASK[7:0]);
        end
        if (bus_take && !hwrite)
        begin
            // Reads clear flags, but a flag set in the same cycle survives, except ready raised by a trigger in idle.
            if (haddr[7:0] == CONFIG_OFS)
            begin
                st_next.rdata = {24'h000000, st_reg.cfg};
            end
            else if (haddr[7:0] == STATUS_OFS)
            begin
                st_next.rdata = {24'h000000, eff_cfg.dec, 1'b0, st_reg.error, st_reg.ready,
                                 st_reg.mode};
                if (!(st_reg.mode == S_RUN && modulator_unstable_flag && !st_reg.flag_prev))
                begin
                    st_next.error = 1'b0;
                end
            end
            else if (haddr[7:0] == DATA_OFS)
            begin
                st_next.rdata = {8'h00, st_reg.word};
                if (!(st_reg.mode == S_RUN && period_end))
                begin
                    st_next.ready = 1'b0;
                end
            end
            else
            begin
                st_next.rdata = 32'h0000_0000;
            end
        end

        // reset clears data and flags, loads pins
        if (st_reg.rst_seen)
        begin
            st_next            = '0;
            st_next.mode       = S_RESET;
            st_next.rst_seen   = reset_request;
            st_next.trig_prev  = trigger_request;
            st_next.cfg        = pin_cfg;
            st_next.word       = CODE_ZERO;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            st_reg      <= '0;
            st_reg.mode <= S_RESET;
        end
        else if (ce)
        begin
            st_reg <= st_next;
        end
    end

    // master clock forced low outside idle and run, strobe forced low only in power-down
    assign modulator_master_clock = st_reg.mclk && (st_reg.mode == S_IDLE || st_reg.mode == S_RUN);
    assign modulator_phase_strobe = st_reg.strobe && (st_reg.mode != S_PDOWN);
    assign word_ready_flag        = st_reg.ready;
    assign word_data              = st_reg.word;
    assign error_flag             = st_reg.error;
    assign hreadyout              = 1'b1;
    assign hresp                  = 1'b0;
    assign hrdata                 = st_reg.rdata;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_reset_recognise: assert property ((ce && reset_request) ##1 ce |=> st_reg.mode == S_RESET)
        else $error("reset pin not recognised on next edge");
    a_reset_release: assert property ((ce && st_reg.mode == S_RESET && !st_reg.rst_seen)
        |=> st_reg.mode != S_RESET)
        else $error("reset state not left");
    a_reset_clear: assert property ((ce && st_reg.rst_seen)
        |=> (word_data == CODE_ZERO && !error_flag && !word_ready_flag))
        else $error("reset did not clear data or flags");
    a_idle_hold: assert property ((ce && st_reg.mode == S_IDLE && !trig_ev && !st_reg.rst_seen
        && !power_down_request) |=> st_reg.mode == S_IDLE)
        else $error("left idle without trigger");
    a_pd_entry: assert property ((ce && power_down_request && !st_reg.rst_seen
        && st_reg.mode != S_RESET) |=> st_reg.mode == S_PDOWN)
        else $error("power-down not entered");
    a_pd_quiet: assert property ((st_reg.mode == S_PDOWN)
        |-> (!modulator_master_clock && !modulator_phase_strobe))
        else $error("modulator outputs active in power-down");
    a_pd_keep: assert property ((ce && st_reg.mode == S_PDOWN && !st_reg.rst_seen)
        |=> $stable(word_data))
        else $error("data lost in power-down");
    a_pd_exit: assert property ((ce && st_reg.mode == S_PDOWN && !power_down_request
        && !st_reg.rst_seen) |=> st_reg.mode == S_IDLE)
        else $error("power-down not left");
    a_first_ready: assert property ((ce && st_reg.mode == S_IDLE && trig_ev && !word_ready_flag
        && !power_down_request && !st_reg.rst_seen)
        |=> (word_ready_flag && st_reg.mode == S_RUN && modulator_phase_strobe))
        else $error("first trigger did not start");
    a_strobe_align: assert property ((ce && modulator_phase_strobe)
        |-> (st_reg.mod_cnt == 3'h0 && st_reg.sample_cnt == 13'h0000))
        else $error("strobe without divider reset");
    a_div_wrap: assert property ((ce && mclk_rise && st_reg.mode == S_RUN && !trig_ev
        && !st_reg.rst_seen && st_reg.mod_cnt == div_last) |=> st_reg.mod_cnt == 3'h0)
        else $error("modulator divider wrong length");
    a_code_range: assert property ($signed(word_data) <= $signed(CODE_POS_FULL)
        && $signed(word_data) >= $signed(CODE_NEG_FULL))
        else $error("output word out of scale");
    a_error_set: assert property ((ce && st_reg.mode == S_RUN && modulator_unstable_flag
        && !st_reg.flag_prev && !st_reg.rst_seen) |=> error_flag)
        else $error("unstable flag did not set error");

    c_start: cover property (st_reg.mode == S_IDLE ##1 st_reg.mode == S_RUN);
    c_word: cover property (ce && period_end);
    c_realign: cover property (ce && trig_ev && st_reg.mode == S_RUN && st_reg.sample_cnt != 0);
    c_pdown: cover property (st_reg.mode == S_RUN ##1 st_reg.mode == S_PDOWN);

endmodule : adc_filter_sync_control

/* File: rtl/adc_sync_pkg.sv */
// Shared constants, register map and state types of the filter sync controller.
package adc_sync_pkg;

    // Clock rate and the modulator master clock that is derived from it.
    localparam int          CLK_HZ          = 25000000;
    localparam int          MCLK_HZ         = 1024000;
    // Longest half period rounds down so the master clock never runs slow.
    localparam int          MCLK_HALF_CYC   = CLK_HZ / (2 * MCLK_HZ);

    // Modulator divider lengths in master clock periods, minus one.
    localparam logic [2:0]  DIV_LAST_FAST   = 3'h3;
    localparam logic [2:0]  DIV_LAST_SLOW   = 3'h7;

    // Decimation: 64 modulator samples per word at the fastest setting.
    localparam logic [3:0]  DEC_BASE_LOG2   = 4'h6;
    localparam logic [2:0]  DEC_MAX_SEL     = 3'h6;
    localparam logic [4:0]  SCALE_LOG2      = 5'h14;
    localparam logic [31:0] SCALE_MULT      = 32'h0000_0005;

    // Output coding of the scaled word.
    localparam logic [23:0] CODE_POS_FULL   = 24'h4FFFFF;
    localparam logic [23:0] CODE_ZERO       = 24'h000000;
    localparam logic [23:0] CODE_NEG_FULL   = 24'hB00000;
    localparam logic [23:0] CODE_POS_OVR    = 24'h53FFFF;
    localparam logic [23:0] CODE_NEG_OVR    = 24'hAC0000;

    // Register byte addresses.
    localparam logic [7:0]  CONFIG_OFS      = 8'h00;
    localparam logic [7:0]  STATUS_OFS      = 8'h04;
    localparam logic [7:0]  DATA_OFS        = 8'h08;
    localparam logic [31:0] CONFIG_WRITE_MASK = 32'h0000_00FF;

    typedef enum logic [1:0] {
        S_RESET = 2'b00,
        S_IDLE  = 2'b01,
        S_RUN   = 2'b10,
        S_PDOWN = 2'b11
    } ctl_mode_t;

    // Configuration register layout, bit 7 down to bit 0.
    typedef struct packed {
        logic       sw_mode;
        logic       cal_req;
        logic       use_off;
        logic       chan;
        logic       high_rate;
        logic [2:0] dec;
    } cfg_t;

    typedef struct packed {
        ctl_mode_t   mode;
        logic        rst_seen;
        logic        trig_prev;
        logic        flag_prev;
        logic [7:0]  div_cnt;
        logic        mclk;
        logic [2:0]  mod_cnt;
        logic        strobe;
        logic [12:0] sample_cnt;
        logic [12:0] ones_cnt;
        logic [23:0] word;
        logic        ready;
        logic        error;
        cfg_t        cfg;
        logic        wr_pend;
        logic [7:0]  wr_addr;
        logic [31:0] rdata;
    } ctl_state_t;

endpackage : adc_sync_pkg

/* File: verif/modulator_model.sv */
// Behavioural delta-sigma modulator facing the filter control block.
`timescale 1ns/1ps
module modulator_model
(
    input  wire logic  clk,
    input  wire logic  master_clock,
    input  wire logic  phase_strobe,
    input  wire logic  ones_level,
    input  wire logic  unstable_cmd,
    output logic       bitstream,
    output logic       unstable_flag,
    output logic [7:0] sync_count
);
    logic       mclk_d;
    logic       strobe_d;
    logic [3:0] idle_cnt;

    initial
    begin
        {mclk_d, strobe_d, bitstream, unstable_flag} = 4'h0;
        idle_cnt = 4'h0;
        sync_count = 8'h00;
    end

    always @(posedge clk)
    begin
        mclk_d <= master_clock;
        strobe_d <= phase_strobe;
        idle_cnt <= (master_clock != mclk_d) ? 4'h0 : idle_cnt + {3'h0, idle_cnt != 4'hF};
        if (phase_strobe && !strobe_d)
            sync_count <= sync_count + 8'h01;
        // A stopped clock powers the model down, so its outputs no longer hold a level.
        bitstream <= (idle_cnt > 4'h8) ? ~bitstream : ones_level;
        unstable_flag <= (idle_cnt > 4'h8) ? ~unstable_flag : unstable_cmd;
    end
endmodule : modulator_model

/* File: verif/adc_filter_sync_control_tb.sv */
// Self-checking bench for the filter sync control block.
`timescale 1ns/1ps
module adc_filter_sync_control_tb;
    import adc_sync_pkg::*;

    typedef struct {
        logic        fast;
        logic [2:0]  dec;
        logic        ones;
        int          gap;
        logic [23:0] code;
    } row_t;

    // Gap is samples per word times master clocks per sample times two clocks.
    row_t rows [4] = '{
        '{1'b1, 3'h0, 1'b1, 32'h200, CODE_POS_FULL},
        '{1'b0, 3'h0, 1'b0, 32'h400, CODE_NEG_FULL},
        '{1'b1, 3'h1, 1'b1, 32'h400, CODE_POS_FULL},
        '{1'b0, 3'h1, 1'b0, 32'h800, CODE_NEG_FULL}};

    logic        clk, resetn, ce, reset_request, power_down_request, trigger_request;
    logic        high_rate_select, decimation_select_2, decimation_select_1;
    logic        decimation_select_0, channel_select, apply_offset_correction;
    logic        offset_cal_request, modulator_bitstream, modulator_unstable_flag;
    logic        modulator_master_clock, modulator_phase_strobe, word_ready_flag;
    logic        error_flag, hsel, hwrite, hreadyout, hresp, ones_level, unstable_cmd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [23:0] word_data, w;
    logic [7:0]  sync_count, syncs;
    int          cyc, err_total, n_tests, t1, t2, tr, hi;

    adc_filter_sync_control #(.MCLK_HALF(1)) dut (
        .clk, .resetn, .ce, .reset_request, .power_down_request, .trigger_request,
        .high_rate_select, .decimation_select_2, .decimation_select_1,
        .decimation_select_0, .channel_select, .apply_offset_correction,
        .offset_cal_request, .modulator_bitstream, .modulator_unstable_flag,
        .modulator_master_clock, .modulator_phase_strobe, .word_ready_flag,
        .word_data, .error_flag, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp, .hrdata);

    modulator_model model (
        .clk, .master_clock(modulator_master_clock), .phase_strobe(modulator_phase_strobe),
        .ones_level, .unstable_cmd, .bitstream(modulator_bitstream),
        .unstable_flag(modulator_unstable_flag), .sync_count);

    always #20 clk = ~clk;

    always @(posedge clk)
        cyc <= cyc + 1;

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    task automatic ahb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                       output logic [31:0] rdata);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, addr};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wdata;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rdata = hrdata;
        check("hresp", hresp, 1'b0);
    endtask : ahb

    task automatic pulse_reset;
        @(posedge clk);
        reset_request <= 1'b1;
        repeat (3) @(posedge clk);
        check("word", word_data, 24'h0);
        check("ready", word_ready_flag, 1'b0);
        check("error", error_flag, 1'b0);
        reset_request <= 1'b0;
        repeat (2) @(posedge clk);
        check("mclk held", modulator_master_clock, 1'b0);
        repeat (2) @(posedge clk);
    endtask : pulse_reset

    // The strobe stands for half a master clock only, so it is looked at mid-cycle.
    task automatic trigger(input logic ready_exp);
        @(posedge clk);
        trigger_request <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        check("strobe", modulator_phase_strobe, 1'b1);
        check("first ready", word_ready_flag, ready_exp);
        @(posedge clk);
    endtask : trigger

    task automatic wait_ready(output int t);
        int n;
        n = 0;
        while (word_ready_flag !== 1'b1 && n < 9000)
        begin
            @(posedge clk);
            n++;
        end
        check("ready wait", n < 9000, 1'b1);
        t = cyc;
    endtask : wait_ready

    initial
    begin
        {clk, resetn, reset_request, power_down_request, trigger_request} = 5'h0;
        {decimation_select_2, decimation_select_1, decimation_select_0} = 3'h0;
        {channel_select, apply_offset_correction, offset_cal_request} = 3'h0;
        {hsel, hwrite, ones_level, unstable_cmd} = 4'h0;
        {ce, high_rate_select} = 2'h3;
        cyc = 0;
        err_total = 0;
        n_tests = 0;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        ahb(1'b0, STATUS_OFS, 32'h0, rd);
        check("status idle", rd, 32'h1);
        foreach (rows[i])
        begin
            high_rate_select <= rows[i].fast;
            {decimation_select_2, decimation_select_1, decimation_select_0} <= rows[i].dec;
            channel_select <= rows[i].ones;
            ones_level <= rows[i].ones;
            pulse_reset();
            ahb(1'b0, CONFIG_OFS, 32'h0, rd);
            check("config", rd, {27'h0, rows[i].ones, rows[i].fast, rows[i].dec});
            syncs = sync_count;
            trigger(1'b1);
            trigger_request <= 1'b0;
            ahb(1'b0, DATA_OFS, 32'h0, rd);
            wait_ready(t1);
            ahb(1'b0, DATA_OFS, 32'h0, rd);
            check("code", rd, {8'h0, rows[i].code});
            wait_ready(t2);
            check("gap", t2 - t1, rows[i].gap);
            check("syncs", sync_count, syncs + 8'h01);
        end
        // Retrigger half way through a word, then hold the pin high.
        ahb(1'b0, DATA_OFS, 32'h0, rd);
        while (cyc < t2 + rows[3].gap / 2) @(posedge clk);
        trigger(1'b0);
        tr = cyc;
        while (cyc < t2 + rows[3].gap + 8) @(posedge clk);
        check("old slot", word_ready_flag, 1'b0);
        wait_ready(t1);
        check("realign", t1 - tr, rows[3].gap - 1);
        ahb(1'b0, DATA_OFS, 32'h0, rd);
        wait_ready(t2);
        check("held gap", t2 - t1, rows[3].gap);
        trigger_request <= 1'b0;
        ahb(1'b0, DATA_OFS, 32'h0, rd);
        w = rd[23:0];
        channel_select <= 1'b0;
        power_down_request <= 1'b1;
        unstable_cmd <= 1'b1;
        repeat (2) @(posedge clk);
        hi = 0;
        repeat (64)
        begin
            if (modulator_master_clock !== 1'b0 || modulator_phase_strobe !== 1'b0)
                hi++;
            @(posedge clk);
        end
        check("pd outputs", hi, 0);
        ahb(1'b0, STATUS_OFS, 32'h0, rd);
        check("pd status", rd, {24'h0, rows[3].dec, 5'h03});
        ahb(1'b0, DATA_OFS, 32'h0, rd);
        check("pd data", rd, {8'h0, w});
        unstable_cmd <= 1'b0;
        power_down_request <= 1'b0;
        repeat (100) @(posedge clk);
        ahb(1'b0, STATUS_OFS, 32'h0, rd);
        check("idle status", rd, {24'h0, rows[3].dec, 5'h01});
        trigger(1'b1);
        trigger_request <= 1'b0;
        unstable_cmd <= 1'b1;
        repeat (4) @(posedge clk);
        check("error set", error_flag, 1'b1);
        ahb(1'b0, STATUS_OFS, 32'h0, rd);
        check("error bit", rd[3], 1'b1);
        @(posedge clk);
        check("error clear", error_flag, 1'b0);
        unstable_cmd <= 1'b0;
        pulse_reset();
        ahb(1'b1, CONFIG_OFS, 32'hFFFF_FF0A, rd);
        ahb(1'b0, CONFIG_OFS, 32'h0, rd);
        check("config rw", rd, 32'h0000_000A);
        ahb(1'b1, 8'h0C, 32'hFFFF_FFFF, rd);
        ahb(1'b0, 8'h0C, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        finish_test();
    end

    initial
    begin
        repeat (40000) @(posedge clk);
        err_total++;
        finish_test();
    end
endmodule : adc_filter_sync_control_tb
